// >>> hw/cdbs_pkg.sv
package cdbs_pkg;
   // ==========================================================
   // Frame layout and timing
   // ==========================================================
   localparam int          DATA_W       = 18;
   localparam int          CNT_W        = 12;
   localparam int          REQ_BITS     = 28;
   localparam int          RSP_BITS     = 24;
   localparam int          STROBE_CYC   = 4;
   localparam int          REPLY_WAIT   = 64;
   localparam int          STARTUP_REF  = 1000;
   localparam logic [4:0]  CRC_POLY     = 5'h05;
   localparam logic [4:0]  CRC_INIT     = 5'h1F;
   localparam logic [1:0]  PLL_X10      = 2'h1;
   localparam logic [1:0]  PLL_X12      = 2'h2;
   localparam logic [1:0]  PLL_RSVD     = 2'h3;
   localparam logic [3:0]  HALF_X8      = 4'h4;
   localparam logic [3:0]  HALF_X10     = 4'h5;
   localparam logic [3:0]  HALF_X12     = 4'h6;
   localparam logic [1:0]  CS_NONE      = 2'h3;

   typedef enum logic [2:0] {
      ST_SLEEP, ST_BOOT, ST_IDLE, ST_TX, ST_WAIT, ST_RX, ST_BUS, ST_DONE
   } cdbs_state_t;

   // One host bus cycle as carried in a request frame.
   typedef struct packed {
      logic [1:0]        cs_n;
      logic              ad;
      logic              rd;
      logic [DATA_W-1:0] data;
   } cdbs_cycle_t;

   typedef struct packed {
      logic [1:0]        cs_n;
      logic              rd_n;
      logic              wr_n;
      logic              ad;
      logic [DATA_W-1:0] data;
   } cdbs_pbus_t;

   function automatic logic [4:0] cdbs_crc5(input logic [21:0] d);
      logic [4:0] c;
      logic       fb;
      c = CRC_INIT;
      for (int i = 21; i >= 0; i--) begin
         fb = c[4] ^ d[i];
         c  = {c[3:0], 1'b0} ^ (fb ? CRC_POLY : 5'h00);
      end
      return c;
   endfunction
endpackage

// >>> hw/cdbs_top.sv
`timescale 1ns/1ps
// Operation
// - Role input high makes the block the host-side end, low the display-side end.
// - Every frame carries a 5-bit CRC which the receiving end checks, for writes and reads.
// - The host-side end raises the error output when a read reply fails its CRC.
// - The display-side end raises the error output when a write frame fails its CRC.
// - With write-only low the display side serves writes and reads, with it high writes only.
// - Sleep request low puts the block to sleep; high lets it run.
// - Start-up completes within about a thousand reference clock cycles.
// - Two chip selects travel across the link so two displays are addressed apart.
// - The host side drives the link clock, the display side receives it; data is two-way.
// - Reference clock and multiplier selects matter only on the host side.
// - The 18-bit data bus carries writes toward the display and reads back toward the host.
// - Multiplier selects give 8, 10 or 12 times; the fourth code is reserved.
// - Strobes are active low and an address/data selector rides with each cycle.
module cdbs_top
   import cdbs_pkg::*;
#(
   parameter int STARTUP_CYCLES = STARTUP_REF
) (
   input  wire logic       clock_in,
   input  wire logic       arst_n_in,
   input  wire logic       host_side_role_in,
   input  wire logic       test_mode_in,
   input  wire logic       sleep_request_n_in,
   input  wire logic       ref_clk_in,
   input  wire logic [1:0] pll_factor_select_in,
   input  wire logic       write_only_in,
   input  wire cdbs_pbus_t pbus_in,
   output cdbs_pbus_t      pbus_out,
   output logic            pbus_ctrl_oe_n_out,
   output logic            pbus_data_oe_n_out,
   input  wire logic       link_clk_in,
   output logic            link_clk_out,
   output logic            link_clk_oe_n_out,
   input  wire logic       link_data_in,
   output logic            link_data_out,
   output logic            link_data_oe_n_out,
   output logic            error_out,
   output logic            ready_out,
   output logic            busy_out
);
   // ==========================================================
   // Input synchronisers
   // ==========================================================
   localparam int SYNC_W = 32;
   logic [SYNC_W-1:0] sync1, sync2;
   logic              lclk_prev, ref_prev;
   wire  [SYNC_W-1:0] raw_in = {host_side_role_in, test_mode_in, sleep_request_n_in,
                                ref_clk_in, pll_factor_select_in, write_only_in,
                                link_clk_in, link_data_in, pbus_in};
   wire cdbs_pbus_t   pbus_s   = sync2[22:0];
   wire               ldata_s  = sync2[23];
   wire               lclk_s   = sync2[24];
   wire               wo_s     = sync2[25];
   wire [1:0]         pll_s    = sync2[27:26];
   wire               ref_s    = sync2[28];
   wire               sleep_n_s = sync2[29];
   wire               test_s   = sync2[30];
   wire               role_s   = sync2[31];

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sync1     <= '0;
         sync2     <= '0;
         lclk_prev <= 1'b0;
         ref_prev  <= 1'b0;
      end else begin
         sync1     <= raw_in;
         sync2     <= sync1;
         lclk_prev <= lclk_s;
         ref_prev  <= ref_s;
      end
   end

   // ==========================================================
   // Link clock generation and edge decode
   // ==========================================================
   cdbs_state_t state, next_state;
   logic [3:0]  half_cnt;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [27:0] shreg, next_shreg;
   cdbs_cycle_t cyc, next_cyc;
   logic        next_err;

   wire [3:0] half_len = (pll_s == PLL_X10) ? HALF_X10 :
                         (pll_s == PLL_X12) ? HALF_X12 : HALF_X8;
   // The clock only stops once low, so the far end never sees a runt pulse.
   wire clk_run  = role_s && (state inside {ST_TX, ST_WAIT, ST_RX} || link_clk_out);
   wire half_end = clk_run && (half_cnt == half_len - 4'h1);
   wire m_rise   = half_end && !link_clk_out;
   wire m_fall   = half_end && link_clk_out;
   wire s_rise   = lclk_s && !lclk_prev;
   wire s_fall   = !lclk_s && lclk_prev;
   wire ref_rise = ref_s && !ref_prev;
   wire sample_tick = role_s ? m_rise : s_rise;
   wire shift_tick  = role_s ? m_fall : s_fall;

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         half_cnt     <= 4'h0;
         link_clk_out <= 1'b0;
      end else begin
         half_cnt     <= half_end || !clk_run ? 4'h0 : half_cnt + 4'h1;
         link_clk_out <= role_s && (half_end ? !link_clk_out : link_clk_out);
      end
   end

   // ==========================================================
   // Frame decode
   // ==========================================================
   wire [26:0] rx_word  = {shreg[25:0], ldata_s};
   wire cdbs_cycle_t rx_cyc = rx_word[26:5];
   wire [DATA_W-1:0] rx_data = rx_word[22:5];
   wire        rx_bad   = role_s ? (cdbs_crc5({4'h0, rx_data}) != rx_word[4:0])
                                 : (cdbs_crc5(rx_cyc) != rx_word[4:0]);
   wire [CNT_W-1:0] rx_last = role_s ? CNT_W'(RSP_BITS - 2) : CNT_W'(REQ_BITS - 2);
   wire [CNT_W-1:0] tx_last = role_s ? CNT_W'(REQ_BITS - 1) : CNT_W'(RSP_BITS - 1);
   wire        rx_done  = (state == ST_RX) && sample_tick && (cnt == rx_last);
   wire        host_req = (pbus_s.cs_n != CS_NONE) && (!pbus_s.rd_n || !pbus_s.wr_n);
   wire        boot_ok  = !test_s && (!role_s || pll_s != PLL_RSVD);
   wire cdbs_cycle_t req_cyc = '{cs_n: pbus_s.cs_n, ad: pbus_s.ad, rd: !pbus_s.rd_n,
                                 data: pbus_s.rd_n ? pbus_s.data : '0};

   // ==========================================================
   // Sequencer
   // ==========================================================
   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_cnt   = cnt;
      next_cyc   = cyc;
      next_err   = error_out;
      unique case (state)
         ST_SLEEP: if (sleep_n_s) begin
            next_state = ST_BOOT;
            next_cnt   = '0;
         end
         ST_BOOT: if (boot_ok) begin
            if (!role_s) next_state = ST_IDLE;
            else if (ref_rise) begin
               next_cnt = cnt + 1'b1;
               if (cnt == CNT_W'(STARTUP_CYCLES - 1)) next_state = ST_IDLE;
            end
         end
         ST_IDLE: if (test_s) begin
            next_state = ST_BOOT;
            next_cnt   = '0;
         end else if (role_s && host_req) begin
            next_cyc   = req_cyc;
            next_shreg = {1'b1, req_cyc, cdbs_crc5(req_cyc)};
            next_state = ST_TX;
            next_cnt   = '0;
            next_err   = 1'b0;
         end else if (!role_s && s_rise && ldata_s) begin
            next_state = ST_RX;
            next_cnt   = '0;
            next_err   = 1'b0;
         end
         ST_TX: if (shift_tick) begin
            next_shreg = {shreg[26:0], 1'b0};
            next_cnt   = cnt + 1'b1;
            if (cnt == tx_last) begin
               next_cnt   = '0;
               next_state = !role_s ? ST_IDLE : (cyc.rd ? ST_WAIT : ST_DONE);
            end
         end
         ST_WAIT: if (role_s) begin
            if (sample_tick && ldata_s) begin
               next_state = ST_RX;
               next_cnt   = '0;
            end else if (sample_tick) begin
               // A refused read never answers; give up with zero data.
               next_cnt = cnt + 1'b1;
               if (cnt == CNT_W'(REPLY_WAIT - 1)) next_state = ST_DONE;
            end
         end else if (s_fall) begin
            // Loading on a falling edge keeps the start bit clear of the next rise.
            next_shreg = {1'b1, cyc.data, cdbs_crc5({4'h0, cyc.data}), 4'h0};
            next_state = ST_TX;
            next_cnt   = '0;
         end
         ST_RX: if (sample_tick) begin
            next_shreg = {shreg[26:0], ldata_s};
            next_cnt   = cnt + 1'b1;
            if (cnt == rx_last) begin
               next_cnt = '0;
               next_err = rx_bad;
               if (role_s) begin
                  next_cyc.data = rx_data;
                  next_state    = ST_DONE;
               end else if (rx_bad || (rx_cyc.rd && wo_s)) begin
                  next_state = ST_IDLE;
               end else begin
                  next_cyc   = rx_cyc;
                  next_state = ST_BUS;
               end
            end
         end
         ST_BUS: begin
            next_cnt = cnt + 1'b1;
            if (cnt == CNT_W'(STROBE_CYC - 1)) begin
               next_cnt = '0;
               if (cyc.rd) begin
                  next_cyc.data = pbus_s.data;
                  next_state    = ST_WAIT;
               end else next_state = ST_IDLE;
            end
         end
         ST_DONE: if (pbus_s.rd_n && pbus_s.wr_n) next_state = ST_IDLE;
      endcase
      if (!sleep_n_s) next_state = ST_SLEEP;
   end

   // ==========================================================
   // Registered outputs
   // ==========================================================
   wire slv_strobe = !role_s && (next_state == ST_BUS);
   wire cdbs_pbus_t next_pbus = '{cs_n: slv_strobe ? next_cyc.cs_n : CS_NONE,
                                  rd_n: !(slv_strobe && next_cyc.rd),
                                  wr_n: !(slv_strobe && !next_cyc.rd),
                                  ad:   next_cyc.ad,
                                  data: next_cyc.data};
   wire next_data_oe = role_s ? (next_state == ST_DONE && next_cyc.rd)
                              : (slv_strobe && !next_cyc.rd);
   wire asleep = next_state == ST_SLEEP;

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state              <= ST_BOOT;
         shreg              <= '0;
         cnt                <= '0;
         cyc                <= '0;
         error_out          <= 1'b0;
         pbus_out           <= '1;
         pbus_ctrl_oe_n_out <= 1'b1;
         pbus_data_oe_n_out <= 1'b1;
         link_clk_oe_n_out  <= 1'b1;
         link_data_out      <= 1'b0;
         link_data_oe_n_out <= 1'b1;
         ready_out          <= 1'b0;
         busy_out           <= 1'b0;
      end else begin
         state              <= next_state;
         shreg              <= next_shreg;
         cnt                <= next_cnt;
         cyc                <= next_cyc;
         error_out          <= next_err;
         pbus_out           <= next_pbus;
         pbus_ctrl_oe_n_out <= role_s || asleep;
         pbus_data_oe_n_out <= !next_data_oe;
         link_clk_oe_n_out  <= !role_s || asleep;
         link_data_out      <= (next_state == ST_TX) && next_shreg[27];
         link_data_oe_n_out <= next_state != ST_TX;
         ready_out          <= !(next_state inside {ST_SLEEP, ST_BOOT});
         busy_out           <= next_state inside {ST_TX, ST_WAIT, ST_RX, ST_BUS, ST_DONE};
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);

   a_sleep_entry: assert property (!sleep_n_s |=> state == ST_SLEEP && link_data_oe_n_out)
      else $error("sleep request did not stop the block");
   a_boot_done: assert property (role_s && state == ST_BOOT && boot_ok && sleep_n_s
      && ref_rise && cnt == CNT_W'(STARTUP_CYCLES - 1) |=> ready_out)
      else $error("start-up count did not end in ready");
   a_slave_ready: assert property (!role_s && state == ST_BOOT && boot_ok && sleep_n_s
      |=> ready_out)
      else $error("display side waited on the reference clock");
   a_pll_reserved: assert property (role_s && pll_s == PLL_RSVD && state == ST_BOOT
      |=> !ready_out)
      else $error("reserved multiplier code became ready");
   a_test_hold: assert property (test_s && state inside {ST_BOOT, ST_IDLE} |=> !ready_out)
      else $error("test mode did not hold the block not ready");
   a_crc_error: assert property (rx_done && rx_bad |=> error_out)
      else $error("crc mismatch not reported");
   a_write_only: assert property (!role_s && rx_done && !rx_bad && rx_cyc.rd && wo_s
      && sleep_n_s |=> state == ST_IDLE ##1 pbus_out.rd_n)
      else $error("read served in write-only mode");
   a_clk_lane_dir: assert property (sleep_n_s && role_s |=> !link_clk_oe_n_out)
      else $error("host side not driving the link clock");
   a_strobe_width: assert property ($fell(pbus_out.wr_n) |->
      (!pbus_out.wr_n && pbus_out.cs_n != CS_NONE)[*4] ##1 pbus_out.wr_n)
      else $error("replayed write strobe has the wrong width");
   a_cs_single: assert property (!pbus_ctrl_oe_n_out |-> pbus_out.cs_n != 2'h0)
      else $error("both chip selects driven low");
   a_read_drive: assert property (!pbus_data_oe_n_out && $past(role_s) |-> cyc.rd)
      else $error("host side drove data on a write");
endmodule

// >>> tb/cdbs_display_model.sv
`timescale 1ns/1ps
module cdbs_display_model
   import cdbs_pkg::*;
(
   input  wire logic              clock_in,
   input  wire logic              arst_n_in,
   input  wire cdbs_pbus_t        dut_pbus_in,
   input  wire logic              ctrl_oe_n_in,
   input  wire logic              data_oe_n_in,
   input  wire logic [DATA_W-1:0] reply_data_in,
   output cdbs_pbus_t             wire_pbus_out,
   output cdbs_pbus_t             last_write_out,
   output logic [7:0]             write_count_out
);
   // ==========================================================
   // Bus wires and display behaviour
   // ==========================================================
   logic              prev_wr_n;
   logic [DATA_W-1:0] last_data;
   wire               ctrl_on = !ctrl_oe_n_in;
   wire               reading = ctrl_on && !dut_pbus_in.rd_n;
   // Control lines have pull-ups; released data shows the inverse of its last level,
   // so a read that the display never answered cannot look right by luck.
   assign wire_pbus_out.cs_n = ctrl_on ? dut_pbus_in.cs_n : CS_NONE;
   assign wire_pbus_out.rd_n = !reading;
   assign wire_pbus_out.wr_n = !(ctrl_on && !dut_pbus_in.wr_n);
   assign wire_pbus_out.ad   = !ctrl_on || dut_pbus_in.ad;
   assign wire_pbus_out.data = !data_oe_n_in ? dut_pbus_in.data :
                               reading ? reply_data_in : ~last_data;
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prev_wr_n       <= 1'h1;
         last_data       <= '0;
         last_write_out  <= '1;
         write_count_out <= 8'h00;
      end else begin
         prev_wr_n <= wire_pbus_out.wr_n;
         last_data <= wire_pbus_out.data;
         if (!wire_pbus_out.wr_n) begin
            last_write_out <= wire_pbus_out;
         end
         if (prev_wr_n && !wire_pbus_out.wr_n) begin
            write_count_out <= write_count_out + 8'h01;
         end
      end
   end
endmodule

// >>> tb/cdbs_top_tb.sv
`timescale 1ns/1ps
module cdbs_top_tb
   import cdbs_pkg::*;
;
   // ==========================================================
   // Clocks, wires and the two ends
   // ==========================================================
   typedef struct packed {logic rd; logic [1:0] cs; logic ad; logic [17:0] d;} cdbs_row_t;
   localparam cdbs_pbus_t IDLE = '{CS_NONE, 1'h1, 1'h1, 1'h1, 18'h00000};
   localparam cdbs_row_t ROWS [6] = '{'{1'h0, 2'h2, 1'h1, 18'h3FFFF},
      '{1'h0, 2'h1, 1'h0, 18'h00000}, '{1'h1, 2'h2, 1'h0, 18'h15A5A},
      '{1'h0, 2'h1, 1'h1, 18'h2AAAA}, '{1'h1, 2'h1, 1'h1, 18'h0FFFF},
      '{1'h0, 2'h2, 1'h0, 18'h12345}};
   logic clock_in = 1'h0, arst_n_in = 1'h0, ref_clk = 1'h0;
   logic sleep_n = 1'h1, wo = 1'h0, glitch = 1'h0, tmode = 1'h0;
   logic [1:0] pll = 2'h0;
   cdbs_pbus_t host_drv = IDLE, h_in, h_out, s_in, s_out, last_wr;
   logic [17:0] reply = 18'h00000;
   logic h_doe, h_lc, h_lcoe, h_ld, h_ldoe, h_err, h_rdy, h_busy;
   logic s_coe, s_doe, s_ld, s_ldoe, s_err, s_rdy, s_lcoe, s_busy, h_coe;
   logic [7:0] wr_cnt;
   int num_errors = 0, checks_done = 0, half_run = 0, half_seen = 0, nw = 0;
   wire link_clk = !h_lcoe & h_lc;
   wire link_dat = ((!h_ldoe & h_ld) | (!s_ldoe & s_ld)) ^ glitch;
   always #10 clock_in = ~clock_in;
   always #100 ref_clk = ~ref_clk;
   always_comb begin
      h_in = host_drv;
      if (!h_doe) h_in.data = h_out.data;
   end
   always @(posedge clock_in) begin
      if (link_clk) half_run <= half_run + 1;
      else if (half_run != 0) begin
         half_seen <= half_run;
         half_run  <= 0;
      end
   end
   // Test mode stays low on both ends except in its own short test.
   cdbs_top #(.STARTUP_CYCLES(8)) dut_u (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .host_side_role_in(1'h1), .test_mode_in(tmode), .sleep_request_n_in(sleep_n),
      .ref_clk_in(ref_clk), .pll_factor_select_in(pll), .write_only_in(wo), .pbus_in(h_in),
      .pbus_out(h_out), .pbus_ctrl_oe_n_out(h_coe), .pbus_data_oe_n_out(h_doe),
      .link_clk_in(link_clk), .link_clk_out(h_lc), .link_clk_oe_n_out(h_lcoe),
      .link_data_in(link_dat), .link_data_out(h_ld), .link_data_oe_n_out(h_ldoe),
      .error_out(h_err), .ready_out(h_rdy), .busy_out(h_busy));
   cdbs_top #(.STARTUP_CYCLES(8)) dut_disp_u (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .host_side_role_in(1'h0), .test_mode_in(tmode), .sleep_request_n_in(sleep_n),
      .ref_clk_in(ref_clk), .pll_factor_select_in(pll), .write_only_in(wo), .pbus_in(s_in),
      .pbus_out(s_out), .pbus_ctrl_oe_n_out(s_coe), .pbus_data_oe_n_out(s_doe),
      .link_clk_in(link_clk), .link_clk_out(), .link_clk_oe_n_out(s_lcoe),
      .link_data_in(link_dat), .link_data_out(s_ld), .link_data_oe_n_out(s_ldoe),
      .error_out(s_err), .ready_out(s_rdy), .busy_out(s_busy));
   cdbs_display_model disp_u (.clock_in(clock_in), .arst_n_in(arst_n_in), .dut_pbus_in(s_out),
      .ctrl_oe_n_in(s_coe), .data_oe_n_in(s_doe), .reply_data_in(reply),
      .wire_pbus_out(s_in), .last_write_out(last_wr), .write_count_out(wr_cnt));
   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   function automatic logic cond(input int k);
      case (k)
         0: return h_rdy & s_rdy;
         1: return h_busy;
         2: return !h_busy;
         3: return !h_doe;
         4: return !s_ldoe;
         5: return !h_ldoe;
         default: return h_ldoe;
      endcase
   endfunction
   // Every wait is bounded; running out of patience ends the run as a mismatch.
   task automatic wait_on(input int k, input int lim);
      for (int n = 0; n < lim && cond(k) !== 1'h1; n++) tick(1);
      if (cond(k) !== 1'h1) begin
         num_errors++;
         $display("[ERR] wait %0d expected done seen timeout", k);
         conclude();
      end
   endtask
   task automatic do_reset(input logic [1:0] p);
      arst_n_in = 1'h0;
      pll = p;
      host_drv = IDLE;
      tick(6);
      check("oe in reset", 18'({h_lcoe, h_ldoe, s_coe, s_doe}), 18'h0000F);
      check("flags in reset", 18'({h_rdy, s_rdy, h_err, s_err}), 18'h00000);
      arst_n_in = 1'h1;
      wait_on(0, 120);
      check("role pins", 18'({h_coe, s_lcoe, s_busy}), 18'h00006);
   endtask
   // Glitch mode 1 flips one request bit, mode 2 one reply bit: one link period wide.
   task automatic bus_cycle(input logic rd, input logic [1:0] cs, input logic ad,
                            input logic [17:0] d, input int g, input logic [17:0] exp_d,
                            input logic exp_err);
      reply = d;
      host_drv = '{cs, !rd, rd, ad, rd ? ~d : d};
      wait_on(1, 10);
      if (g != 0) fork
         begin
            if (g == 2) wait_on(4, 2000);
            tick(40);
            glitch = 1'h1;
            tick(8);
            glitch = 1'h0;
         end
      join_none
      if (rd) begin
         wait_on(3, 2000);
         if (!exp_err) check("read data", h_out.data, exp_d);
         check("host error", 18'(h_err), 18'(exp_err));
      end else begin
         wait_on(5, 50);
         wait_on(6, 400);
      end
      host_drv = IDLE;
      wait_on(2, 20);
      tick(20);
   endtask
   // ==========================================================
   // Sequence
   // ==========================================================
   initial begin
      do_reset(2'h0);
      for (int i = 0; i < 6; i++) begin
         bus_cycle(ROWS[i].rd, ROWS[i].cs, ROWS[i].ad, ROWS[i].d, 0, ROWS[i].d, 1'h0);
         if (!ROWS[i].rd) begin
            nw++;
            check("replay cs ad", 18'({last_wr.cs_n, last_wr.ad}),
                  18'({ROWS[i].cs, ROWS[i].ad}));
            check("replay data", last_wr.data, ROWS[i].d);
         end
         check("write count", 18'(wr_cnt), 18'(nw));
         $display("row %0d done", i);
      end
      bus_cycle(1'h0, 2'h2, 1'h0, 18'h0468A, 1, 18'h0, 1'h0);
      check("display error", 18'(s_err), 18'h00001);
      check("bad write dropped", 18'(wr_cnt), 18'(nw));
      bus_cycle(1'h0, 2'h1, 1'h1, 18'h30C0C, 0, 18'h0, 1'h0);
      nw++;
      check("display error cleared", 18'(s_err), 18'h00000);
      bus_cycle(1'h1, 2'h1, 1'h0, 18'h13579, 2, 18'h13579, 1'h1);
      $display("crc test done");
      wo = 1'h1;
      bus_cycle(1'h1, 2'h2, 1'h1, 18'h2ABCD, 0, 18'h00000, 1'h0);
      bus_cycle(1'h0, 2'h2, 1'h1, 18'h1F0F0, 0, 18'h0, 1'h0);
      nw++;
      check("write under write-only", 18'(wr_cnt), 18'(nw));
      wo = 1'h0;
      $display("write-only test done");
      sleep_n = 1'h0;
      tick(10);
      check("asleep", 18'({h_rdy, s_rdy, h_lcoe, s_coe}), 18'h00003);
      sleep_n = 1'h1;
      wait_on(0, 150);
      $display("sleep test done");
      tmode = 1'h1;
      tick(10);
      check("test mode holds", 18'({h_rdy, s_rdy}), 18'h00000);
      tmode = 1'h0;
      wait_on(0, 150);
      $display("test mode test done");
      for (int p = 0; p < 3; p++) begin
         do_reset(2'(p));
         // A 12-bit host: its six top data inputs are tied low.
         bus_cycle(1'h0, 2'h1, 1'h0, 18'h00F0F, 0, 18'h0, 1'h0);
         check("narrow host data", last_wr.data, 18'h00F0F);
         check("link half period", 18'(half_seen), 18'(4 + p));
      end
      arst_n_in = 1'h0;
      pll = 2'h3;
      tick(6);
      arst_n_in = 1'h1;
      tick(200);
      check("reserved factor not ready", 18'(h_rdy), 18'h00000);
      check("display ignores factor", 18'(s_rdy), 18'h00001);
      $display("factor test done");
      conclude();
   end
endmodule
